// ===== verilog/wrm_pkg.sv
// Constants and types shared by the window reference mode mapper
`default_nettype none
package wrm_pkg;
  localparam int PHYS_BASE_W = 24;
  localparam int DISP_W = 16;
  localparam int SEL_W = 16;
  localparam int NUM_WIN = 4;
  localparam int WIN_W = 2;
  localparam logic [WIN_W-1:0] SWITCH_WIN = 2'h1;
  localparam logic [PHYS_BASE_W-1:0] PROC_ID_ADDR = 24'h000000;
  localparam logic [PHYS_BASE_W-1:0] IPM_ADDR = 24'h000002;
  localparam logic RST_PHYS_MODE = 1'b0;
  localparam logic RST_W1_ICON = 1'b0;
  localparam int FUNC_W = 4;
  // Functions still accepted in physical mode, one bit per function code
  localparam logic [15:0] PHYS_FUNC_MASK = 16'h0007;
  localparam logic [3:0] RIGHT_READ = 4'h1;
  localparam logic [3:0] RIGHT_WRITE = 4'h2;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LOOK = 4'b0010,
    ST_CHECK = 4'b0100,
    ST_DONE = 4'b1000
  } ref_state_type;
endpackage : wrm_pkg
`default_nettype wire

// ===== verilog/wrm_addr_gen.sv
// Base plus displacement adder with interconnect alignment check
`default_nettype none
module wrm_addr_gen #(
  parameter int BASE_W = 24,
  parameter int DISP_W = 16
) (
  input wire logic [BASE_W-1:0] base,
  input wire logic [DISP_W-1:0] disp,
  input wire logic icon_space,
  output logic [BASE_W-1:0] addr,
  output logic misaligned
);
  always_comb begin
    addr = base + BASE_W'(disp);
    misaligned = icon_space & addr[0];
  end
endmodule : wrm_addr_gen
`default_nettype wire

// ===== verilog/window_reference_mode_mapper.sv
// Window address development in logical and physical reference modes
`default_nettype none
module window_reference_mode_mapper #(
  parameter int NUM_WIN = wrm_pkg::NUM_WIN
) (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic SET_MODE,
  input wire logic SET_PHYS,
  input wire logic SET_SPACE,
  input wire logic SET_ICON,
  input wire logic OPEN,
  input wire logic [wrm_pkg::WIN_W-1:0] OPEN_WIN,
  input wire logic [wrm_pkg::PHYS_BASE_W-1:0] OPEN_BASE,
  input wire logic [wrm_pkg::SEL_W-1:0] OPEN_SEL,
  input wire logic DESC_VALID,
  input wire logic [wrm_pkg::PHYS_BASE_W-1:0] DESC_BASE,
  input wire logic [wrm_pkg::DISP_W-1:0] DESC_LEN,
  input wire logic [3:0] DESC_RIGHTS,
  input wire logic DESC_DATA_SEG,
  input wire logic REF_REQ,
  input wire logic [wrm_pkg::WIN_W-1:0] REF_WIN,
  input wire logic [wrm_pkg::DISP_W-1:0] REF_OFS,
  input wire logic REF_WRITE,
  input wire logic FUNC_REQ,
  input wire logic [wrm_pkg::FUNC_W-1:0] FUNC_CODE,
  output logic PHYS_MODE,
  output logic W1_ICON,
  output logic DESC_REQ,
  output logic [wrm_pkg::SEL_W-1:0] DESC_SEL,
  output logic BUS_REQ,
  output logic BUS_ICON,
  output logic BUS_WRITE,
  output logic [wrm_pkg::PHYS_BASE_W-1:0] BUS_ADDR,
  output logic REF_FAULT,
  output logic REG_PROC_ID,
  output logic REG_IPM,
  output logic FUNC_ACCEPT,
  output logic FUNC_REJECT
);
  logic rst_s1_q, rst_s2_q;
  wire logic rst_n = rst_s2_q;
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  function automatic logic is_switch_win(input logic [wrm_pkg::WIN_W-1:0] w);
    return w == wrm_pkg::SWITCH_WIN;
  endfunction

  // Mode bits; a reference already in flight keeps the space it was started with
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      PHYS_MODE <= wrm_pkg::RST_PHYS_MODE;
      W1_ICON <= wrm_pkg::RST_W1_ICON;
    end else begin
      if (SET_MODE) PHYS_MODE <= SET_PHYS;
      if (SET_SPACE) W1_ICON <= SET_ICON;
    end
  end

  // Per-window mapping state
  logic [wrm_pkg::PHYS_BASE_W-1:0] base_q [NUM_WIN];
  logic [wrm_pkg::DISP_W-1:0] len_q [NUM_WIN];
  logic [3:0] rights_q [NUM_WIN];
  logic [NUM_WIN-1:0] open_q, logical_q, data_q;
  // Only one lookup may be outstanding; logical opens arriving meanwhile are dropped
  logic pend_q;
  logic [wrm_pkg::WIN_W-1:0] pend_win_q;

  // Descriptor lookup for logical opens
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      DESC_REQ <= 1'b0;
      DESC_SEL <= '0;
      pend_q <= 1'b0;
      pend_win_q <= '0;
    end else begin
      if (OPEN && !PHYS_MODE && !pend_q) begin
        DESC_REQ <= 1'b1;
        DESC_SEL <= OPEN_SEL;
        pend_q <= 1'b1;
        pend_win_q <= OPEN_WIN;
      end else if (pend_q && DESC_VALID) begin
        DESC_REQ <= 1'b0;
        pend_q <= 1'b0;
      end
    end
  end

  // A physical open outranks a lookup completing for the same window in one cycle
  genvar g;
  generate
    for (g = 0; g < NUM_WIN; g++) begin : g_win
      always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
          base_q[g] <= '0;
          len_q[g] <= '0;
          rights_q[g] <= '0;
          open_q[g] <= 1'b0;
          logical_q[g] <= 1'b0;
          data_q[g] <= 1'b0;
        end else if (OPEN && PHYS_MODE && OPEN_WIN == g) begin
          base_q[g] <= OPEN_BASE;
          open_q[g] <= 1'b1;
          logical_q[g] <= 1'b0;
        end else if (pend_q && DESC_VALID && pend_win_q == g) begin
          base_q[g] <= DESC_BASE;
          len_q[g] <= DESC_LEN;
          rights_q[g] <= DESC_RIGHTS;
          data_q[g] <= DESC_DATA_SEG;
          open_q[g] <= 1'b1;
          logical_q[g] <= 1'b1;
        end
      end
    end
  endgenerate

  // Reference path
  logic icon_sel;
  logic [wrm_pkg::PHYS_BASE_W-1:0] tgt_addr;
  logic misaligned;
  logic prot_fail;
  always_comb begin
    icon_sel = is_switch_win(REF_WIN) && W1_ICON;
    prot_fail = 1'b0;
    if (logical_q[REF_WIN] && !PHYS_MODE) begin
      // Bounds, rights and segment type checks
      prot_fail = (REF_OFS >= len_q[REF_WIN]) || !data_q[REF_WIN] ||
        ((REF_WRITE ? (rights_q[REF_WIN] & wrm_pkg::RIGHT_WRITE)
                    : (rights_q[REF_WIN] & wrm_pkg::RIGHT_READ)) == 4'h0);
    end
    if (PHYS_MODE) prot_fail = 1'b0;
  end

  // One adder serves both spaces; only interconnect references must land on even addresses
  wrm_addr_gen #(
    .BASE_W(wrm_pkg::PHYS_BASE_W),
    .DISP_W(wrm_pkg::DISP_W)
  ) u_addr (
    .base(base_q[REF_WIN]),
    .disp(REF_OFS),
    .icon_space(icon_sel),
    .addr(tgt_addr),
    .misaligned(misaligned)
  );

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      BUS_REQ <= 1'b0;
      BUS_ICON <= 1'b0;
      BUS_WRITE <= 1'b0;
      BUS_ADDR <= '0;
      REF_FAULT <= 1'b0;
      REG_PROC_ID <= 1'b0;
      REG_IPM <= 1'b0;
    end else begin
      BUS_REQ <= 1'b0;
      REF_FAULT <= 1'b0;
      REG_PROC_ID <= 1'b0;
      REG_IPM <= 1'b0;
      if (REF_REQ) begin
        // A window left stale by a mode change faults rather than misroute
        if (!open_q[REF_WIN] || misaligned || prot_fail ||
            (logical_q[REF_WIN] == PHYS_MODE)) begin
          REF_FAULT <= 1'b1;
        end else begin
          BUS_REQ <= 1'b1;
          BUS_ICON <= icon_sel;
          BUS_WRITE <= REF_WRITE;
          BUS_ADDR <= tgt_addr;
          REG_PROC_ID <= icon_sel && tgt_addr == wrm_pkg::PROC_ID_ADDR;
          REG_IPM <= icon_sel && tgt_addr == wrm_pkg::IPM_ADDR;
        end
      end
    end
  end

  // Function requests
  // Logical mode accepts every code; the mask only narrows what physical mode allows
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      FUNC_ACCEPT <= 1'b0;
      FUNC_REJECT <= 1'b0;
    end else begin
      FUNC_ACCEPT <= 1'b0;
      FUNC_REJECT <= 1'b0;
      if (FUNC_REQ) begin
        if (PHYS_MODE && !wrm_pkg::PHYS_FUNC_MASK[FUNC_CODE]) begin
          FUNC_REJECT <= 1'b1;
        end else begin
          FUNC_ACCEPT <= 1'b1;
        end
      end
    end
  end
endmodule : window_reference_mode_mapper
`default_nettype wire

// ===== bench/wrm_desc_model.sv
// Descriptor lookup responder standing in for the object tables
`default_nettype none
module wrm_desc_model (
  input wire logic clk, rst_n, req, dseg,
  input wire logic [1:0] lat,
  input wire logic [3:0] rts,
  input wire logic [23:0] base,
  output logic valid, data_seg,
  output logic [3:0] rights,
  output logic [15:0] len,
  output logic [23:0] d_base
);
  logic [1:0] cnt_q;
  // Inverted while no answer stands, so a stale field can never pass
  assign d_base = valid ? base : ~base;
  assign rights = valid ? rts : ~rts;
  assign data_seg = valid ? dseg : !dseg;
  assign len = valid ? 16'h0100 : 16'hFEFF;
  // One answer per lookup after lat idle cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 2'h0;
      valid <= 1'h0;
    end else if (!req || valid) begin
      cnt_q <= 2'h0;
      valid <= 1'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      valid <= cnt_q == lat;
    end
  end
endmodule // wrm_desc_model
`default_nettype wire

// ===== bench/window_reference_mode_mapper_props.sv
// Port checker for the window mapper
`default_nettype none
module wrm_chk (
  input wire logic CLOCK, ARST_N, SET_MODE, SET_PHYS, SET_SPACE, SET_ICON, OPEN,
  input wire logic REF_REQ, FUNC_REQ, PHYS_MODE, W1_ICON, DESC_REQ, BUS_REQ, BUS_ICON,
  input wire logic REF_FAULT, REG_PROC_ID, REG_IPM, FUNC_ACCEPT, FUNC_REJECT,
  input wire logic [15:0] OPEN_SEL, DESC_SEL,
  input wire logic [1:0] REF_WIN,
  input wire logic [3:0] FUNC_CODE,
  input wire logic [23:0] BUS_ADDR
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  property p_md; SET_MODE |=> PHYS_MODE == $past(SET_PHYS); endproperty
  a_md: assert property (p_md) else $error("mode");
  property p_sp; SET_SPACE |=> W1_ICON == $past(SET_ICON); endproperty
  a_sp: assert property (p_sp) else $error("space");
  property p_an; REF_REQ |=> BUS_REQ != REF_FAULT; endproperty
  a_an: assert property (p_an) else $error("answer");
  property p_ev; BUS_REQ && BUS_ICON |-> !BUS_ADDR[0] && $past(REF_WIN) == 2'h1; endproperty
  a_ev: assert property (p_ev) else $error("icon ref");
  property p_id; REG_PROC_ID |-> BUS_REQ && BUS_ICON && BUS_ADDR == 24'h0; endproperty
  a_id: assert property (p_id) else $error("proc id");
  property p_ipm; REG_IPM |-> BUS_REQ && BUS_ICON && BUS_ADDR == 24'h2; endproperty
  a_ipm: assert property (p_ipm) else $error("ipm");
  property p_fn;
    FUNC_REQ |=> FUNC_ACCEPT != FUNC_REJECT &&
      FUNC_REJECT == ($past(PHYS_MODE) && $past(FUNC_CODE) > 4'h2);
  endproperty
  a_fn: assert property (p_fn) else $error("func");
  property p_ds; OPEN && !PHYS_MODE && !DESC_REQ |=> DESC_REQ && DESC_SEL == $past(OPEN_SEL);
  endproperty
  a_ds: assert property (p_ds) else $error("lookup");
endmodule // wrm_chk
bind window_reference_mode_mapper wrm_chk i_chk (.*);
`default_nettype wire

// ===== bench/window_reference_mode_mapper_tb_top.sv
// Self-checking bench for the window mapper
`default_nettype none
module window_reference_mode_mapper_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLOCK = '0, ARST_N = '0, SET_MODE = '0, SET_PHYS = '0, SET_SPACE = '0, SET_ICON = '0;
  logic OPEN = '0, REF_REQ = '0, REF_WRITE = '0, FUNC_REQ = '0, dseg = '0;
  logic [1:0] OPEN_WIN = '0, REF_WIN = '0, lat = '0;
  logic [3:0] FUNC_CODE = '0, rts = '0, DESC_RIGHTS;
  logic [15:0] OPEN_SEL = '0, REF_OFS = '0, DESC_LEN, DESC_SEL;
  logic [23:0] OPEN_BASE = '0, base = '0, DESC_BASE, BUS_ADDR;
  logic DESC_VALID, DESC_DATA_SEG, PHYS_MODE, W1_ICON, DESC_REQ, BUS_REQ, BUS_ICON, BUS_WRITE;
  logic REF_FAULT, REG_PROC_ID, REG_IPM, FUNC_ACCEPT, FUNC_REJECT;
  int errors = 0, n_compared = 0, cyc = 0;
  typedef struct {bit p, i, d; bit [1:0] w; bit [3:0] r; bit [23:0] b; bit [15:0] o; bit f;} row_type;
  row_type rows[10] = '{'{1, 0, 0, 0, 0, 24'h123456, 16'hFFFE, 0},
    '{1, 1, 0, 1, 0, 24'h0, 16'h0, 0}, '{1, 1, 0, 1, 0, 24'h0, 16'h2, 0},
    '{1, 1, 0, 1, 0, 24'h100, 16'h3, 1}, '{1, 1, 0, 0, 0, 24'h0, 16'h2, 0},
    '{0, 0, 1, 2, 1, 24'h1000, 16'hFF, 0}, '{0, 0, 1, 2, 1, 24'h1000, 16'h100, 1},
    '{0, 0, 1, 3, 2, 24'h2000, 16'h10, 1}, '{0, 0, 0, 3, 1, 24'h2000, 16'h10, 1},
    '{0, 1, 1, 1, 1, 24'h0, 16'h2, 0}};
  window_reference_mode_mapper i_dut (.*);
  wrm_desc_model i_desc (.clk(CLOCK), .rst_n(ARST_N), .req(DESC_REQ), .dseg(dseg), .lat(lat),
    .rts(rts), .base(base), .valid(DESC_VALID), .data_seg(DESC_DATA_SEG), .rights(DESC_RIGHTS),
    .len(DESC_LEN), .d_base(DESC_BASE));
  always #20 CLOCK = !CLOCK;
  task automatic conclude();
    if (errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Ceiling of 4000 cycles sits well above the fewer than two hundred cycles the sequence needs
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      conclude();
    end
  end
  task automatic tick(); @(posedge CLOCK); #5; endtask
  task automatic chk(string n, logic [23:0] e, g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic setm(bit p, i);
    {SET_MODE, SET_PHYS, SET_SPACE, SET_ICON} = {1'h1, p, 1'h1, i};
    tick();
    {SET_MODE, SET_SPACE} = '0;
  endtask
  task automatic opn(bit [1:0] w, bit [23:0] b);
    {OPEN, OPEN_WIN, OPEN_BASE, OPEN_SEL} = {1'h1, w, b, b[15:0]};
    tick();
    OPEN = '0;
    for (int k = 0; k < 9 && DESC_REQ === 1'h1; k++) tick();
  endtask
  task automatic rf(bit [1:0] w, bit [15:0] o);
    {REF_REQ, REF_WIN, REF_OFS} = {1'h1, w, o};
    tick();
    REF_REQ = '0;
  endtask
  initial begin
    repeat (8) @(posedge CLOCK);
    #5 ARST_N = '1;
    repeat (3) tick();
    chk("mode", 0, PHYS_MODE);
    chk("icon", 0, W1_ICON);
    foreach (rows[k]) begin
      bit [23:0] a;
      bit ic;
      a = rows[k].b + rows[k].o;
      ic = rows[k].i && rows[k].w == 2'h1 && !rows[k].f;
      {base, rts, dseg, lat} = {rows[k].b, rows[k].r, rows[k].d, 2'(k % 4)};
      setm(rows[k].p, rows[k].i);
      chk("mode", rows[k].p, PHYS_MODE);
      chk("icon", rows[k].i, W1_ICON);
      opn(rows[k].w, rows[k].b);
      rf(rows[k].w, rows[k].o);
      chk("fault", rows[k].f, REF_FAULT);
      chk("req", !rows[k].f, BUS_REQ);
      chk("id", ic && a == 0, REG_PROC_ID);
      chk("ipm", ic && a == 2, REG_IPM);
      if (!rows[k].f) chk("addr", a, BUS_ADDR);
      if (!rows[k].f) chk("bicon", ic, BUS_ICON);
    end
    setm(1, 0);
    opn(3, 24'h4000);
    setm(0, 0);
    rf(3, 0);
    chk("fault", 1, REF_FAULT);
    setm(1, 0);
    opn(2, 24'hABCDEF);
    {REF_REQ, REF_WIN, REF_OFS} = {1'h1, 2'h2, 16'h10};
    tick();
    chk("addr", 24'hABCDFF, BUS_ADDR);
    REF_OFS = 16'h11;
    tick();
    chk("addr", 24'hABCE00, BUS_ADDR);
    REF_REQ = '0;
    setm(0, 0);
    {base, rts, dseg} = {24'h3000, 4'h2, 1'h1};
    opn(3, 24'h3000);
    chk("sel", 16'h3000, DESC_SEL);
    REF_WRITE = '1;
    rf(3, 16'h20);
    chk("fault", 0, REF_FAULT);
    chk("write", 1, BUS_WRITE);
    chk("addr", 24'h3020, BUS_ADDR);
    rts = 4'h1;
    opn(3, 24'h3000);
    rf(3, 16'h20);
    chk("fault", 1, REF_FAULT);
    REF_WRITE = '0;
    for (int m = 0; m < 2; m++) begin
      setm(m[0], 0);
      for (int c = 0; c < 16; c++) begin
        {FUNC_REQ, FUNC_CODE} = {1'h1, 4'(c)};
        tick();
        FUNC_REQ = '0;
        chk("rej", m == 1 && c > 2, FUNC_REJECT);
        chk("acc", !(m == 1 && c > 2), FUNC_ACCEPT);
        tick();
      end
    end
    ARST_N = '0;
    tick();
    chk("mode", 0, PHYS_MODE);
    chk("write", 0, BUS_WRITE);
    chk("addr", 0, BUS_ADDR);
    ARST_N = '1;
    repeat (3) tick();
    rf(2, 16'h10);
    chk("fault", 1, REF_FAULT);
    conclude();
  end
endmodule // window_reference_mode_mapper_tb_top
`default_nettype wire
